// file: core/boot_loader_pkg.sv
// shared constants and types for the boot-time image loader
package boot_loader_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned BOOT_DELAY_US = 15;
    localparam int unsigned BOOT_DELAY_CYC = BOOT_DELAY_US * CLK_MHZ;
    localparam int unsigned SEC_BOOT_BIT = 5;
    localparam logic [31:0] NO_CRC_MARK = 32'h0d15ab1e;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [7:0] QSPI_READ_CMD = 8'heb;
    localparam logic [2:0] PLL_OD_RESET = 3'h1;
    localparam logic [11:0] PLL_F_RESET = 12'h03f;
    localparam logic [5:0] PLL_R_RESET = 6'h00;
    localparam logic [3:0] QSPI_DUMMY_CYC = 4'h6;
    // register byte addresses
    localparam logic [3:0] REG_PLL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SECURITY = 4'h8;
    localparam logic [3:0] REG_LENGTH = 4'hc;
    localparam int unsigned PLL_OD_LSB = 0;
    localparam int unsigned PLL_F_LSB = 8;
    localparam int unsigned PLL_R_LSB = 24;

    typedef struct packed {
        logic [5:0] ref_div;
        logic [11:0] feedback;
        logic [2:0] pll_output_divider;
    } pll_cfg_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] data;
        logic we;
    } ram_wr_type;
endpackage

// file: core/crc32_byte.sv
// one-byte step of the reflected crc-32
`timescale 1ns/100ps
module crc32_byte (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data,
    output logic [31:0] crc_out
);
    import boot_loader_pkg::*;
    always_comb begin
        logic [31:0] c;
        c = crc_in ^ {24'h000000, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        crc_out = c;
    end
endmodule // crc32_byte

// file: core/qspi_byte_reader.sv
// quad spi sequential reader: command, address 0, dummy, then byte stream
`timescale 1ns/100ps
module qspi_byte_reader (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic stop,
    input wire logic [3:0] sio_in,
    output logic [3:0] sio_out,
    output logic [3:0] sio_oe,
    output logic sck,
    output logic cs_n,
    output logic [7:0] byte_data,
    output logic byte_valid
);
    import boot_loader_pkg::*;
    typedef enum logic [4:0] {
        Q_IDLE = 5'b00001,
        Q_CMD = 5'b00010,
        Q_ADDR = 5'b00100,
        Q_DUMMY = 5'b01000,
        Q_DATA = 5'b10000
    } q_state_type;
    q_state_type state_q;
    logic [4:0] cnt_q;
    logic [23:0] shift_q;
    logic [3:0] nib_q;
    logic half_q;
    logic [3:0] sio_s1_q, sio_s2_q;

    always_ff @(posedge clk) begin
        sio_s1_q <= sio_in;
        sio_s2_q <= sio_s1_q;
    end

    // sck runs at clk/2; outputs change on falling sck, inputs also taken on falling sck
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= Q_IDLE;
            cnt_q <= 5'h00;
            sck <= 1'b0;
            cs_n <= 1'b1;
            sio_out <= 4'h0;
            sio_oe <= 4'h0;
            shift_q <= 24'h000000;
            nib_q <= 4'h0;
            half_q <= 1'b0;
            byte_data <= 8'h00;
            byte_valid <= 1'b0;
        end else begin
            byte_valid <= 1'b0;
            unique case (state_q)
                Q_IDLE: begin
                    sck <= 1'b0;
                    if (start) begin
                        cs_n <= 1'b0;
                        sio_oe <= 4'h1;
                        sio_out <= {3'h0, QSPI_READ_CMD[7]};
                        shift_q <= {QSPI_READ_CMD[6:0], 17'h00000};
                        cnt_q <= 5'h07;
                        state_q <= Q_CMD;
                    end
                end
                Q_CMD: begin
                    sck <= ~sck;
                    if (sck) begin
                        if (cnt_q == 5'h00) begin
                            sio_oe <= 4'hf;
                            sio_out <= 4'h0; // address 0, nibble wide
                            cnt_q <= 5'h05;
                            state_q <= Q_ADDR;
                        end else begin
                            sio_out <= {3'h0, shift_q[23]};
                            shift_q <= {shift_q[22:0], 1'b0};
                            cnt_q <= cnt_q - 5'h01;
                        end
                    end
                end
                Q_ADDR: begin
                    sck <= ~sck;
                    if (sck) begin
                        if (cnt_q == 5'h00) begin
                            sio_oe <= 4'h0;
                            cnt_q <= {1'b0, QSPI_DUMMY_CYC};
                            state_q <= Q_DUMMY;
                        end else begin
                            cnt_q <= cnt_q - 5'h01;
                        end
                    end
                end
                Q_DUMMY: begin
                    sck <= ~sck;
                    if (sck) begin
                        cnt_q <= cnt_q - 5'h01;
                        if (cnt_q == 5'h01) begin
                            half_q <= 1'b0;
                            state_q <= Q_DATA;
                        end
                    end
                end
                Q_DATA: begin
                    if (stop) begin
                        cs_n <= 1'b1;
                        sck <= 1'b0;
                        state_q <= Q_IDLE;
                    end else begin
                        sck <= ~sck;
                        // sample late (synchroniser delay absorbed by slow sck)
                        if (sck) begin
                            half_q <= ~half_q;
                            if (half_q) begin
                                byte_data <= {nib_q, sio_s2_q};
                                byte_valid <= 1'b1;
                            end else begin
                                nib_q <= sio_s2_q;
                            end
                        end
                    end
                end
                default: state_q <= Q_IDLE;
            endcase
        end
    end
endmodule // qspi_byte_reader

// file: core/boot_image_loader.sv
// boot loader top: reset hold, pll init, boot source choice, image load, crc
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module boot_image_loader #(
    parameter int unsigned GPIO_W = 8,
    parameter int unsigned BOOT_DELAY = boot_loader_pkg::BOOT_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rst_n_pin,
    input wire logic [31:0] otp_security,
    input wire logic otp_valid,
    input wire logic [3:0] qspi_sio_in,
    output logic [3:0] qspi_sio_out,
    output logic [3:0] qspi_sio_oe,
    output logic qspi_sck,
    output logic qspi_cs_n,
    output boot_loader_pkg::ram_wr_type ram_wr,
    output boot_loader_pkg::pll_cfg_type pll_cfg,
    output logic pll_update,
    output logic [GPIO_W-1:0] gpio_pulldown,
    output logic core_run,
    output logic [31:0] start_addr,
    output logic boot_from_otp,
    output logic boot_fail,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import boot_loader_pkg::*;

    typedef enum logic [7:0] {
        S_RESET = 8'b00000001,
        S_DELAY = 8'b00000010,
        S_SECLD = 8'b00000100,
        S_LEN = 8'b00001000,
        S_PROG = 8'b00010000,
        S_TRAIL = 8'b00100000,
        S_RUN = 8'b01000000,
        S_FAIL = 8'b10000000
    } boot_state_type;

    boot_state_type state_q;
    logic rst_s1_q, rst_s2_q;
    logic [31:0] delay_q;
    logic [31:0] sec_q;
    logic [31:0] len_q;
    logic [31:0] word_q;
    logic [1:0] bcnt_q;
    logic [31:0] addr_q;
    logic [31:0] crc_q;
    logic [31:0] crc_next;
    logic [7:0] rd_byte;
    logic rd_valid;
    logic rd_start_q;
    logic rd_stop;
    logic [31:0] trail_word;
    logic in_reset;
    logic acc_q;

    // external reset pin is asynchronous to clk
    always_ff @(posedge clk) begin
        rst_s1_q <= rst_n_pin;
        rst_s2_q <= rst_s1_q;
    end
    assign in_reset = rst | ~rst_s2_q;

    crc32_byte u_crc (
        .crc_in(crc_q),
        .data(rd_byte),
        .crc_out(crc_next)
    );

    assign rd_stop = (state_q == S_RUN) || (state_q == S_FAIL);

    qspi_byte_reader u_qspi (
        .clk(clk),
        .rst(in_reset),
        .start(rd_start_q),
        .stop(rd_stop),
        .sio_in(qspi_sio_in),
        .sio_out(qspi_sio_out),
        .sio_oe(qspi_sio_oe),
        .sck(qspi_sck),
        .cs_n(qspi_cs_n),
        .byte_data(rd_byte),
        .byte_valid(rd_valid)
    );

    assign trail_word = {rd_byte, word_q[31:8]};

    // boot sequencing
    always_ff @(posedge clk) begin
        if (in_reset) begin
            state_q <= S_RESET;
            delay_q <= 32'h00000000;
            sec_q <= 32'h00000000;
            len_q <= 32'h00000000;
            word_q <= 32'h00000000;
            bcnt_q <= 2'h0;
            addr_q <= 32'h00000000;
            crc_q <= CRC_INIT;
            rd_start_q <= 1'b0;
            core_run <= 1'b0;
            start_addr <= 32'h00000000;
            boot_from_otp <= 1'b0;
            boot_fail <= 1'b0;
            ram_wr <= '0;
        end else begin
            rd_start_q <= 1'b0;
            ram_wr.we <= 1'b0;
            unique case (state_q)
                S_RESET: state_q <= S_DELAY;
                S_DELAY: begin
                    delay_q <= delay_q + 32'h00000001;
                    if (delay_q >= 32'(BOOT_DELAY - 1)) begin
                        state_q <= S_SECLD;
                    end
                end
                S_SECLD: begin
                    if (otp_valid) begin
                        sec_q <= otp_security;
                        if (otp_security[SEC_BOOT_BIT]) begin
                            boot_from_otp <= 1'b1;
                            start_addr <= 32'h00000000;
                            core_run <= 1'b1;
                            state_q <= S_RUN;
                        end else begin
                            rd_start_q <= 1'b1;
                            state_q <= S_LEN;
                        end
                    end
                end
                S_LEN, S_PROG, S_TRAIL: begin
                    if (rd_valid) begin
                        word_q <= trail_word;
                        bcnt_q <= bcnt_q + 2'h1;
                        if (state_q != S_TRAIL) begin
                            crc_q <= crc_next;
                        end
                        if (state_q == S_PROG) begin
                            ram_wr.we <= 1'b1;
                            ram_wr.addr <= addr_q;
                            ram_wr.data <= rd_byte;
                            addr_q <= addr_q + 32'h00000001;
                        end
                        if (bcnt_q == 2'h3) begin
                            if (state_q == S_LEN) begin
                                len_q <= trail_word;
                                state_q <= (trail_word == 32'h00000000) ? S_TRAIL : S_PROG;
                            end else if (state_q == S_PROG) begin
                                if (addr_q[31:2] + 30'h00000001 == len_q[29:0]) begin
                                    state_q <= S_TRAIL;
                                end
                            end else if (trail_word == NO_CRC_MARK
                                         || trail_word == ~crc_q) begin
                                core_run <= 1'b1;
                                start_addr <= 32'h00000000;
                                state_q <= S_RUN;
                            end else begin
                                boot_fail <= 1'b1;
                                state_q <= S_FAIL;
                            end
                        end
                    end
                end
                S_RUN: state_q <= S_RUN;
                S_FAIL: state_q <= S_FAIL;
                default: state_q <= S_FAIL;
            endcase
        end
    end

    // pull-downs on while held in reset
    always_ff @(posedge clk) begin
        gpio_pulldown <= in_reset ? {GPIO_W{1'b1}} : {GPIO_W{1'b0}};
    end

    // pll config: reset values, updated on software write
    always_ff @(posedge clk) begin
        if (in_reset) begin
            pll_cfg.pll_output_divider <= PLL_OD_RESET;
            pll_cfg.feedback <= PLL_F_RESET;
            pll_cfg.ref_div <= PLL_R_RESET;
            pll_update <= 1'b1;
        end else begin
            pll_update <= 1'b0;
            // write lands only at the edge where the master sees waitrequest low
            if (avs_write && !avs_waitrequest && avs_address == REG_PLL && &avs_byteenable) begin
                pll_cfg.pll_output_divider <= avs_writedata[PLL_OD_LSB +: 3];
                pll_cfg.feedback <= avs_writedata[PLL_F_LSB +: 12];
                pll_cfg.ref_div <= avs_writedata[PLL_R_LSB +: 6];
                pll_update <= 1'b1;
            end
        end
    end

    // avalon slave: one wait cycle, answer on second edge
    always_ff @(posedge clk) begin
        if (in_reset) begin
            acc_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            acc_q <= (avs_read || avs_write) && !acc_q;
            avs_waitrequest <= !((avs_read || avs_write) && !acc_q);
            if (avs_read && !acc_q) begin
                unique case (avs_address)
                    REG_PLL: avs_readdata <= {2'h0, pll_cfg.ref_div, 4'h0,
                        pll_cfg.feedback, 5'h00, pll_cfg.pll_output_divider};
                    REG_STATUS: avs_readdata <= {24'h000000, state_q};
                    REG_SECURITY: avs_readdata <= sec_q;
                    REG_LENGTH: avs_readdata <= len_q;
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    AST_PULLDOWN_IN_RESET: assert property (@(posedge clk)
        in_reset |=> gpio_pulldown == {GPIO_W{1'b1}})
        else $error("pull-down not enabled during reset");
    AST_HOLD_RESET: assert property (@(posedge clk)
        in_reset |=> state_q == S_RESET && !core_run)
        else $error("left reset while reset asserted");
    AST_PLL_RESET: assert property (@(posedge clk)
        in_reset |=> pll_cfg.feedback == 12'h03f && pll_cfg.pll_output_divider == 3'h1
        && pll_cfg.ref_div == 6'h00)
        else $error("pll reset values wrong");
    AST_PLL_WRITE: assert property (@(posedge clk) disable iff (in_reset)
        avs_write && !avs_waitrequest && avs_address == REG_PLL && &avs_byteenable
        |=> pll_cfg.feedback == $past(avs_writedata[19:8]) && pll_update)
        else $error("pll write not applied");
    AST_DELAY_MIN: assert property (@(posedge clk) disable iff (in_reset)
        $rose(state_q == S_SECLD) |-> delay_q >= 32'(BOOT_DELAY - 1))
        else $error("boot started too early");
    AST_SECURE_BOOT: assert property (@(posedge clk) disable iff (in_reset)
        state_q == S_SECLD && otp_valid && otp_security[5]
        |=> core_run && boot_from_otp && start_addr == 32'h00000000)
        else $error("secure boot not taken");
    AST_FLASH_START: assert property (@(posedge clk) disable iff (in_reset)
        state_q == S_SECLD && otp_valid && !otp_security[5] |=> rd_start_q)
        else $error("flash read not started");
    AST_RAM_ADDR: assert property (@(posedge clk) disable iff (in_reset)
        state_q == S_PROG && rd_valid |=> ram_wr.we && ram_wr.addr == $past(addr_q))
        else $error("program byte not written in order");
    AST_FAIL_NO_RUN: assert property (@(posedge clk) disable iff (in_reset)
        boot_fail |-> !core_run)
        else $error("program started after crc failure");
    AST_CRC_INIT: assert property (@(posedge clk)
        in_reset |=> crc_q == 32'hffffffff)
        else $error("crc not initialised");
endmodule // boot_image_loader

// file: testbench/qspi_flash_model.sv
// behavioural quad spi boot flash answering a sequential quad read from address 0
`timescale 1ns/100ps
module qspi_flash_model (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] sio_out,
    output logic [3:0] dq,
    output logic cmd_ok
);
    logic [7:0] mem [0:63];
    logic [7:0] cmd;
    logic [23:0] adr;
    int unsigned edges;
    initial begin
        dq = 4'h5;
        cmd_ok = 1'b0;
        edges = 0;
    end
    // released lines flip instead of holding a stale nibble
    always @(posedge cs_n) dq <= ~dq;
    always @(negedge cs_n) begin
        edges = 0;
        cmd_ok = 1'b0;
    end
    always @(posedge sck) begin
        if (!cs_n) begin
            if (edges < 8) cmd = {cmd[6:0], sio_out[0]};
            else if (edges < 14) adr = {adr[19:0], sio_out};
            if (edges == 13) cmd_ok = (cmd === 8'heb) && (adr === 24'h0);
            // nibble goes out three clocks ahead of its sampling edge, high half first
            if (edges >= 19 && edges < 147) begin
                dq <= ((edges - 19) % 2 == 0) ? mem[(edges - 19) / 2][7:4]
                                              : mem[(edges - 19) / 2][3:0];
            end
            edges++;
        end
    end
endmodule // qspi_flash_model

// file: testbench/boot_image_loader_tb.sv
// self-checking bench for the boot image loader
`timescale 1ns/100ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %0t: %s", $time, m); end end
module boot_image_loader_tb;
    import boot_loader_pkg::*;
    localparam int DLY = 20;
    logic clk, rst, rst_n_pin, otp_valid, avs_read, avs_write, avs_waitrequest, pll_update;
    logic core_run, boot_from_otp, boot_fail, qspi_sck, qspi_cs_n, cmd_ok, cs_low;
    logic [31:0] otp_security, avs_writedata, avs_readdata, start_addr, rd;
    logic [3:0] qspi_sio_in, qspi_sio_out, qspi_sio_oe, avs_address, avs_byteenable, fdq;
    logic [7:0] gpio_pulldown;
    ram_wr_type ram_wr;
    pll_cfg_type pll_cfg;
    int bad_count = 0;
    int compares = 0;
    int wr_idx = 0;
    int upd_cnt = 0;
    assign qspi_sio_in = (qspi_sio_oe & qspi_sio_out) | (~qspi_sio_oe & fdq);
    boot_image_loader #(.BOOT_DELAY(DLY)) dut (.clk(clk), .rst(rst), .rst_n_pin(rst_n_pin),
        .otp_security(otp_security), .otp_valid(otp_valid), .qspi_sio_in(qspi_sio_in),
        .qspi_sio_out(qspi_sio_out), .qspi_sio_oe(qspi_sio_oe), .qspi_sck(qspi_sck),
        .qspi_cs_n(qspi_cs_n), .ram_wr(ram_wr), .pll_cfg(pll_cfg), .pll_update(pll_update),
        .gpio_pulldown(gpio_pulldown), .core_run(core_run), .start_addr(start_addr),
        .boot_from_otp(boot_from_otp), .boot_fail(boot_fail), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    qspi_flash_model flash (.sck(qspi_sck), .cs_n(qspi_cs_n), .sio_out(qspi_sio_out),
        .dq(fdq), .cmd_ok(cmd_ok));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst) begin
            wr_idx <= 0;
            cs_low <= 1'b0;
        end else begin
            if (ram_wr.we) begin
                `CHK(ram_wr.addr, 32'(wr_idx), "ram address")
                `CHK(ram_wr.data, flash.mem[4 + wr_idx], "ram data")
                wr_idx <= wr_idx + 1;
            end
            if (pll_update) upd_cnt <= upd_cnt + 1;
            if (!qspi_cs_n) cs_low <= 1'b1;
        end
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            bad_count++;
            $display("ERROR %0t: bus timeout", $time);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // mode 0 correct crc, 1 no-check marker, 2 corrupted crc
    task automatic load(input int s, input int mode);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 4 * s + 4; i++) begin
            flash.mem[i] = (i < 4) ? 8'(s >> (8 * i)) : 8'(i * 37 + 5);
            c ^= 32'(flash.mem[i]);
            for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        c = ~c;
        if (mode == 1) c = 32'h0d15ab1e;
        if (mode == 2) c ^= 32'h1;
        for (int i = 0; i < 4; i++) flash.mem[4 * s + 4 + i] = c[8 * i +: 8];
    endtask
    task automatic boot(input int s, input int mode);
        int n = 0;
        load(s, mode);
        rst <= 1'b1;
        otp_valid <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        while (qspi_cs_n === 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK(n >= DLY && n <= 10 * DLY, 1'b1, "boot delay")
        n = 0;
        while (core_run !== 1'b1 && boot_fail !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK(cmd_ok, 1'b1, "flash read command")
        `CHK(wr_idx, 4 * s, "program byte count")
        `CHK(start_addr, 32'h0, "start address")
        `CHK(boot_from_otp, 1'b0, "boot source")
    endtask
    task automatic t_pll;
        int u;
        bus(1'b0, REG_PLL, 32'h0, 4'hf);
        `CHK(rd, 32'h00003f01, "pll reset value")
        u = (pll_cfg.feedback + 1) / 2 / (pll_cfg.ref_div + 1)
            / (pll_cfg.pll_output_divider + 1);
        `CHK(u, 16, "ratio")
        `CHK(24 * u, 384, "boot tile clock from a usb oscillator")
        u = upd_cnt;
        // boot already done; vco stays in range for a 24 MHz oscillator
        bus(1'b1, REG_PLL, 32'h02006303, 4'hf);
        repeat (2) @(posedge clk);
        `CHK(pll_cfg, {6'h02, 12'h063, 3'h3}, "pll settings")
        `CHK(upd_cnt, u + 1, "pll update pulse")
        bus(1'b1, REG_PLL, 32'h0, 4'h1);
        bus(1'b0, REG_PLL, 32'h0, 4'hf);
        `CHK(rd, 32'h02006303, "partial write ignored")
        bus(1'b0, 4'h2, 32'h0, 4'hf);
        `CHK(rd, 32'h0, "unmapped read")
        $display("test pll registers done");
    endtask
    task automatic t_good;
        boot(3, 0);
        `CHK(core_run, 1'b1, "good image runs")
        `CHK(boot_fail, 1'b0, "no failure")
        bus(1'b0, REG_LENGTH, 32'h0, 4'hf);
        `CHK(rd, 32'd3, "length register")
        bus(1'b0, REG_STATUS, 32'h0, 4'hf);
        `CHK($countones(rd), 1, "status one-hot")
        $display("test good crc done");
    endtask
    task automatic t_pin;
        rst_n_pin <= 1'b0;
        repeat (30) @(posedge clk);
        `CHK(gpio_pulldown, 8'hff, "pull-downs in reset")
        `CHK(core_run, 1'b0, "held in reset")
        `CHK(qspi_cs_n, 1'b1, "flash idle in reset")
        `CHK(pll_cfg, {PLL_R_RESET, PLL_F_RESET, PLL_OD_RESET}, "pll back to reset")
        rst_n_pin <= 1'b1;
        $display("test reset pin done");
    endtask
    task automatic t_nocrc;
        boot(2, 1);
        `CHK(core_run, 1'b1, "marker skips check")
        `CHK(boot_fail, 1'b0, "marker no failure")
        $display("test no-check marker done");
    endtask
    task automatic t_bad;
        boot(1, 2);
        `CHK(core_run, 1'b0, "bad crc not run")
        `CHK(boot_fail, 1'b1, "bad crc flagged")
        $display("test bad crc done");
    endtask
    task automatic t_secure;
        rst <= 1'b1;
        otp_security <= 32'h20;
        otp_valid <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (DLY + 20) @(posedge clk);
        `CHK(core_run, 1'b0, "waits for security word")
        otp_valid <= 1'b1;
        repeat (DLY + 20) @(posedge clk);
        `CHK(boot_from_otp, 1'b1, "one-time memory boot")
        `CHK(core_run, 1'b1, "secure boot runs")
        bus(1'b0, REG_SECURITY, 32'h0, 4'hf);
        `CHK(rd, 32'h20, "security word latched")
        `CHK(start_addr, 32'h0, "one-time start address")
        `CHK(cs_low, 1'b0, "flash untouched")
        otp_security <= 32'h0;
        $display("test secure boot done");
    endtask
    initial begin
        rst = 1'b1;
        rst_n_pin = 1'b1;
        // security word not ready until a test offers it
        otp_valid = 1'b0;
        otp_security = 32'h0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (3) @(posedge clk);
        `CHK(gpio_pulldown, 8'hff, "pull-downs at start")
        `CHK(pll_update, 1'b1, "pll loaded in reset")
        `CHK(core_run, 1'b0, "no run in reset")
        @(posedge clk);
        rst <= 1'b0;
        t_good();
        t_pll();
        t_pin();
        t_nocrc();
        t_bad();
        t_secure();
        give_verdict();
    end
    initial begin
        #(8 * 40000);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule // boot_image_loader_tb
